// [core/nand_busy_timer.sv]
// Purpose: Counts the busy window after a command and flags overrun.
// Assumes: ready_busy_n arrives synchronous to ref_clk.
// Notes: Overrun marks a device busier than its limit allows.
`timescale 1ns/1ps
`include "nand_host_defs.svh"
module nand_busy_timer #(
  parameter int CW = 20
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Control.
  input wire logic start,
  input wire logic [CW-1:0] limit,
  input wire logic ready_busy_n,
  // Status.
  output logic done,
  output logic overrun
);
  logic [CW-1:0] count_r;
  logic [3:0] wb_r;
  logic active_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      wb_r <= 4'h0;
      active_r <= 1'b0;
      done <= 1'b0;
      overrun <= 1'b0;
    end else begin
      done <= 1'b0;
      // Overrun is a one-cycle pulse so that the host's sticky flag can be cleared.
      overrun <= 1'b0;
      if (start) begin
        count_r <= '0;
        wb_r <= 4'(`WB_CYCLES);
        active_r <= 1'b1;
        overrun <= 1'b0;
      end else if (active_r) begin
        count_r <= count_r + 1'b1;
        if (wb_r != 4'h0) begin
          wb_r <= wb_r - 4'h1;
        end else if (ready_busy_n) begin
          active_r <= 1'b0;
          done <= 1'b1;
        end
        if (count_r == limit) begin
          overrun <= 1'b1;
        end
      end
    end
  end
endmodule

// [core/nand_host.sv]
// Purpose: Drives a NAND flash through its strobes and shared byte port.
// Assumes: One request at a time; inputs synchronous to ref_clk.
// Notes: Each strobe phase lasts PHASE_CYCLES clocks, above the 12 ns pulse minimum.
`timescale 1ns/1ps
`include "nand_host_defs.svh"
module nand_host #(
  parameter int CW = 20,
  parameter logic [CW-1:0] LOAD_CYC = CW'(`US_TO_CYCLES(`ARRAY_LOAD_US)),
  parameter logic [CW-1:0] CW_SHORT_CYC = CW'(`US_TO_CYCLES(`CACHE_WRITE_SHORT_US)),
  parameter logic [CW-1:0] CW_LONG_CYC = CW'(`US_TO_CYCLES(`CACHE_WRITE_LONG_US)),
  parameter logic [CW-1:0] CR_CYC = CW'(`US_TO_CYCLES(`CACHE_READ_US)),
  parameter logic [CW-1:0] COPY_CYC = CW'(`US_TO_CYCLES(`COPY_READ_US)),
  parameter logic [CW-1:0] LONG_CYC = CW'(`US_TO_CYCLES(`BLOCK_ERASE_MS * 1000))
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // User request.
  input wire logic reqValid,
  input wire nand_host_pkg::req_t req,
  input wire logic protect,
  output logic reqReady,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic timeoutErr,
  // Flash pins.
  output nand_host_pkg::pins_t pins,
  output logic [7:0] ioOut,
  output logic ioOe_n,
  input wire logic [7:0] ioIn,
  input wire logic ready_busy_n
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LOW = 3'b001,
    S_HIGH = 3'b011,
    S_BUSY = 3'b010,
    S_GAP = 3'b110
  } state_t;

  state_t state_r;
  nand_host_pkg::req_t cur_r;
  logic [2:0] addrIdx_r;
  logic [2:0] phase_r;
  logic [7:0] lastCmd_r;
  logic [2:0] partial_r;
  logic timerStart;
  logic timerDone;
  logic timerOver;
  logic [CW-1:0] limit;

  // Address byte layout for the five address cycles.
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [12:0] col,
                                           input logic [16:0] row);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      3'h0: b = col[7:0];
      3'h1: b = {3'b000, col[12:8]};
      3'h2: b = row[7:0];
      3'h3: b = row[15:8];
      default: b = {7'h00, row[16]};
    endcase
    return b;
  endfunction

  // Busy limit per confirming command.
  function automatic logic [CW-1:0] busy_limit(input logic [7:0] c);
    logic [CW-1:0] l;
    l = LONG_CYC;
    if (c == `CMD_READ2) l = LOAD_CYC;
    else if (c == `CMD_CACHE_WRITE) l = CW_SHORT_CYC;
    else if (c == `CMD_CACHE_PROG) l = CW_LONG_CYC;
    else if (c == `CMD_CACHE_READ || c == `CMD_CACHE_READ_END) l = CR_CYC;
    else if (c == `CMD_COPY_READ) l = COPY_CYC;
    return l;
  endfunction

  function automatic logic starts_busy(input logic [7:0] c);
    return c == `CMD_READ2 || c == `CMD_CACHE_WRITE || c == `CMD_CACHE_PROG ||
           c == `CMD_CACHE_READ || c == `CMD_CACHE_READ_END || c == `CMD_COPY_READ ||
           c == `CMD_PROG_CONFIRM || c == `CMD_ERASE_CONFIRM || c == `CMD_RESET;
  endfunction

  assign limit = busy_limit(cur_r.data);
  assign timerStart = (state_r == S_HIGH) && (phase_r == 3'h0) &&
                      (cur_r.op == nand_host_pkg::OP_CMD) && starts_busy(cur_r.data);

  nand_busy_timer #(.CW(CW)) u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(timerStart),
    .limit(limit),
    .ready_busy_n(ready_busy_n),
    .done(timerDone),
    .overrun(timerOver)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      cur_r <= '0;
      phase_r <= 3'h0;
      addrIdx_r <= 3'h0;
      reqReady <= 1'b0;
    end else begin
      reqReady <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          reqReady <= !reqValid;
          if (reqValid && !reqReady) begin
          end else if (reqValid) begin
            cur_r <= req;
            addrIdx_r <= 3'h0;
            phase_r <= 3'(`PHASE_CYCLES - 1);
            // Waiting on ready is the caller's OP_WAIT request.
            state_r <= (req.op == nand_host_pkg::OP_WAIT) ? S_BUSY : S_LOW;
          end
        end
        S_LOW: begin
          if (phase_r != 3'h0) begin
            phase_r <= phase_r - 3'h1;
          end else begin
            phase_r <= 3'(`PHASE_CYCLES - 1);
            state_r <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (phase_r != 3'h0) begin
            phase_r <= phase_r - 3'h1;
          end else if (cur_r.op == nand_host_pkg::OP_ADDR &&
                       addrIdx_r != 3'(`ADDR_CYCLES - 1)) begin
            addrIdx_r <= addrIdx_r + 3'h1;
            phase_r <= 3'(`PHASE_CYCLES - 1);
            state_r <= S_LOW;
          end else if (timerStart) begin
            state_r <= S_BUSY;
          end else begin
            state_r <= S_GAP;
          end
        end
        S_BUSY: begin
          if (timerDone || (cur_r.op == nand_host_pkg::OP_WAIT && ready_busy_n)) begin
            state_r <= S_GAP;
          end
        end
        S_GAP: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pins <= '{cmdLatch: 1'b0, addrLatch: 1'b0, chipSel_n: 1'b1, writeStrobe_n: 1'b1,
                output_strobe_n: 1'b1, writeProt_n: 1'b0};
      ioOut <= 8'h00;
      ioOe_n <= 1'b1;
    end else begin
      pins.writeProt_n <= !protect;
      pins.cmdLatch <= 1'b0;
      pins.addrLatch <= 1'b0;
      pins.writeStrobe_n <= 1'b1;
      pins.output_strobe_n <= 1'b1;
      ioOe_n <= 1'b1;
      // Select is dropped only when idle so standby follows ready.
      pins.chipSel_n <= (state_r == S_IDLE) && !reqValid;
      if (state_r == S_LOW || state_r == S_HIGH) begin
        unique case (cur_r.op)
          nand_host_pkg::OP_CMD: begin
            pins.cmdLatch <= 1'b1;
            pins.writeStrobe_n <= state_r != S_LOW;
            ioOut <= cur_r.data;
            ioOe_n <= 1'b0;
          end
          nand_host_pkg::OP_ADDR: begin
            pins.addrLatch <= 1'b1;
            pins.writeStrobe_n <= state_r != S_LOW;
            ioOut <= addr_byte(addrIdx_r, cur_r.col, cur_r.row);
            ioOe_n <= 1'b0;
          end
          nand_host_pkg::OP_WRITE: begin
            pins.writeStrobe_n <= state_r != S_LOW;
            ioOut <= cur_r.data;
            ioOe_n <= 1'b0;
          end
          nand_host_pkg::OP_READ: begin
            // Port left undriven while the device drives it.
            pins.output_strobe_n <= state_r != S_LOW;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read capture, command history and timing errors
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
      timeoutErr <= 1'b0;
      lastCmd_r <= `CMD_READ1;
      partial_r <= 3'h0;
    end else begin
      rdValid <= 1'b0;
      if (state_r == S_HIGH && phase_r == 3'h0 && cur_r.op == nand_host_pkg::OP_READ) begin
        // Sample at the end of the high phase, one cycle after the read strobe has risen.
        rdData <= ioIn;
        rdValid <= 1'b1;
      end
      if (timerOver) begin
        timeoutErr <= 1'b1;
      end else if (reqValid && reqReady) begin
        timeoutErr <= 1'b0;
      end
      if (timerStart || (state_r == S_HIGH && cur_r.op == nand_host_pkg::OP_CMD)) begin
        lastCmd_r <= cur_r.data;
      end
      if (timerStart && cur_r.data == `CMD_PROG_CONFIRM) begin
        partial_r <= (partial_r == 3'(`PARTIAL_PROG_MAX)) ? partial_r : partial_r + 3'h1;
      end else if (timerStart && cur_r.data == `CMD_ERASE_CONFIRM) begin
        partial_r <= 3'h0;
      end
    end
  end
endmodule

// [core/nand_host_defs.svh]
// Purpose: Constants for the NAND flash host controller.
// Assumes: 125 MHz ref_clk, 8 ns period.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef NAND_HOST_DEFS_SVH
`define NAND_HOST_DEFS_SVH

`define CLK_PERIOD_NS 8
`define PHASE_CYCLES 2
`define ADDR_CYCLES 5
`define PAGE_MAIN_BYTES 4096
`define PAGE_SPARE_BYTES 256
`define PAGE_BYTES 4352
`define PAGES_PER_BLOCK 64
`define BLOCK_COUNT 2048
`define PARTIAL_PROG_MAX 4
`define ARRAY_LOAD_US 25
`define CACHE_WRITE_SHORT_US 10
`define CACHE_WRITE_LONG_US 700
`define CACHE_READ_US 25
`define COPY_READ_US 30
`define BLOCK_ERASE_MS 5
`define US_TO_CYCLES(us) (((us) * 1000) / `CLK_PERIOD_NS)
`define WB_NS 100
`define WB_CYCLES ((`WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_PROG_CONFIRM 8'h10
`define CMD_CACHE_WRITE 8'h11
`define CMD_CACHE_PROG 8'h15
`define CMD_CACHE_READ 8'h31
`define CMD_CACHE_READ_END 8'h3F
`define CMD_COPY_READ 8'h3A
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_STATUS 8'h70
`define CMD_STATUS_MULTI 8'h71
`define CMD_RESET 8'hFF
`define CMD_DATA_IN 8'h80
`define CMD_MULTI_DATA_IN 8'h81
`define CMD_ERASE 8'h60

`endif

// [core/nand_host_pkg.sv]
// Purpose: Types for the NAND flash host controller.
// Assumes: Nothing beyond the constants header.
// Notes: Request and pin groups travel as packed structs.
package nand_host_pkg;

  typedef enum logic [2:0] {
    OP_CMD = 3'h0,
    OP_ADDR = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h3,
    OP_WAIT = 3'h4
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] data;
    logic [16:0] row;
    logic [12:0] col;
  } req_t;

  typedef struct packed {
    logic cmdLatch;
    logic addrLatch;
    logic chipSel_n;
    logic writeStrobe_n;
    logic output_strobe_n;
    logic writeProt_n;
  } pins_t;

endpackage

// [tb/nand_dev_model.sv]
// Purpose: Behavioural NAND device facing nand_host.
// Assumes: Pins change only after ref_clk rising edges.
// Notes: busyLen sets each busy period; a read byte is column xor row.
`timescale 1ns/1ps
module nand_dev_model (
  // Clock.
  input wire logic ref_clk,
  // Pins.
  input wire nand_host_pkg::pins_t pins,
  input wire logic [7:0] ioOut,
  output logic [7:0] ioIn,
  output logic busy,
  // Control.
  input wire logic [15:0] busyLen
);
  nand_host_pkg::pins_t prev;
  logic [7:0] cmdR = 8'h00;
  logic [7:0] wrData;
  logic [39:0] addrR;
  int addrCnt = 0;
  int col = 0;
  int cnt = 0;
  int progStarts = 0;
  initial ioIn = 8'h5A;
  assign busy = cnt != 0;
  always @(posedge ref_clk) begin
    prev <= pins;
    if (cnt != 0) cnt <= cnt - 1;
    if (!prev.writeStrobe_n && pins.writeStrobe_n && !pins.chipSel_n) begin
      if (pins.cmdLatch) begin
        cmdR <= ioOut;
        addrCnt <= 0;
        if (ioOut inside {8'h10, 8'h11, 8'h15, 8'hD0}) begin
          if (pins.writeProt_n) begin
            cnt <= busyLen;
            progStarts <= progStarts + 1;
          end
        end else if (ioOut inside {8'h30, 8'h31, 8'h3F, 8'h3A}) begin
          cnt <= busyLen;
          col <= addrR[12:0];
        end
      end else if (pins.addrLatch) begin
        addrR[8*addrCnt +: 8] <= ioOut;
        addrCnt <= addrCnt + 1;
      end else begin
        wrData <= ioOut;
      end
    end
    if (prev.output_strobe_n && !pins.output_strobe_n) begin
      ioIn <= col[7:0] ^ addrR[23:16];
      col <= col + 1;
    end else if ((!prev.cmdLatch && pins.cmdLatch) || (!prev.addrLatch && pins.addrLatch) ||
        (!prev.chipSel_n && pins.chipSel_n) || (prev.writeStrobe_n && !pins.writeStrobe_n)) begin
      ioIn <= ~ioIn;
    end
  end
endmodule

// [tb/nand_host_chk.sv]
// Purpose: Pin and handshake assertions for nand_host.
// Assumes: One clock domain.
// Notes: Bound to every nand_host instance.
`timescale 1ns/1ps
module nand_host_chk (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // User side.
  input wire logic reqValid,
  input wire nand_host_pkg::req_t req,
  input wire logic protect,
  input wire logic reqReady,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic timeoutErr,
  // Flash pins.
  input wire nand_host_pkg::pins_t pins,
  input wire logic [7:0] ioOut,
  input wire logic ioOe_n,
  input wire logic [7:0] ioIn,
  input wire logic ready_busy_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_oe_read: assert property (!pins.output_strobe_n |-> ioOe_n)
    else $error("host drives port while reading");
  chk_wp_follow: assert property (1 |=> pins.writeProt_n == !$past(protect))
    else $error("write protect pin does not follow protect");
  chk_ready_first: assert property ($rose(reqReady) |-> ready_busy_n)
    else $error("idle while device busy");
  chk_rd_pulse: assert property (rdValid |-> pins.output_strobe_n ##1 !rdValid)
    else $error("read valid pulse malformed");
  chk_strobe_fall: assert property ($fell(pins.output_strobe_n) |-> ioOe_n &&
    pins.writeStrobe_n && !pins.cmdLatch && !pins.addrLatch && !pins.chipSel_n)
    else $error("read strobe fell in wrong state");
  chk_write_pulse: assert property ($fell(pins.writeStrobe_n) |->
    !pins.writeStrobe_n [*2] ##1 pins.writeStrobe_n)
    else $error("write strobe low time wrong");
  chk_data_hold: assert property ($rose(pins.writeStrobe_n) |-> $stable(ioOut) &&
    (pins.cmdLatch || pins.addrLatch || !ioOe_n))
    else $error("port not held at write strobe rise");
  chk_latch_excl: assert property (!(pins.cmdLatch && pins.addrLatch))
    else $error("both latches high");
  cover property (rdValid);
  cover property ($rose(timeoutErr));
  cover property ($rose(pins.writeStrobe_n) && pins.addrLatch);
endmodule
bind nand_host nand_host_chk nand_host_chk_inst (.ref_clk(ref_clk), .rstn(rstn),
  .reqValid(reqValid), .req(req), .protect(protect), .reqReady(reqReady), .rdData(rdData),
  .rdValid(rdValid), .timeoutErr(timeoutErr), .pins(pins), .ioOut(ioOut), .ioOe_n(ioOe_n),
  .ioIn(ioIn), .ready_busy_n(ready_busy_n));

// [tb/tb.sv]
// Purpose: Self-checking bench for nand_host with a device model.
// Assumes: Busy limits shortened through parameters.
// Notes: Expected bytes come from a queue model of the device.
`timescale 1ns/1ps
`define CHECK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  localparam int LOAD = 60, SHORT = 40, CWLONG = 90, CR = 50, COPY = 70;
  logic ref_clk, rstn, reqValid, protect, reqReady, rdValid, timeoutErr, ioOe_n, busy;
  nand_host_pkg::req_t req;
  nand_host_pkg::pins_t pins;
  logic [7:0] rdData, ioOut, ioIn, d;
  logic [15:0] busyLen;
  logic [16:0] r;
  logic [12:0] c;
  logic [7:0] rdq[$];
  int expq[$];
  int num_errors = 0, check_count = 0, n;
  wire rbLevel = !busy;
  nand_host #(.LOAD_CYC(20'(LOAD)), .CW_SHORT_CYC(20'(SHORT)), .CW_LONG_CYC(20'(CWLONG)),
    .CR_CYC(20'(CR)), .COPY_CYC(20'(COPY)), .LONG_CYC(20'h78)) nand_host_inst (
    .ref_clk(ref_clk), .rstn(rstn), .reqValid(reqValid), .req(req), .protect(protect),
    .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .timeoutErr(timeoutErr),
    .pins(pins), .ioOut(ioOut), .ioOe_n(ioOe_n), .ioIn(ioIn), .ready_busy_n(rbLevel));
  nand_dev_model nand_dev_model_inst (.ref_clk(ref_clk), .pins(pins), .ioOut(ioOut),
    .ioIn(ioIn), .busy(busy), .busyLen(busyLen));
  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (rdValid === 1'b1) rdq.push_back(rdData);
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    while (reqReady !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      k++;
      if (k > 5000) begin
        num_errors++;
        tally_and_finish();
      end
    end
  endtask
  task automatic do_req(input nand_host_pkg::op_t op, input logic [7:0] dt);
    wait_ready();
    req = '{op: op, data: dt, row: r, col: c};
    reqValid = 1'b1;
    @(posedge ref_clk);
    #1;
    reqValid = 1'b0;
    wait_ready();
  endtask
  task automatic busy_cmd(input logic [7:0] cc, input int lim, input logic slow);
    busyLen = slow ? 16'(lim * 2) : 16'(lim / 2);
    do_req(nand_host_pkg::OP_CMD, cc);
    `CHECK(timeoutErr, slow)
  endtask
  task automatic read_n(input int num);
    logic [7:0] g;
    int e;
    for (int i = 0; i < num; i++) begin
      do_req(nand_host_pkg::OP_READ, 8'h00);
      expq.push_back((c + i) ^ r[7:0]);
    end
    repeat (2) @(posedge ref_clk);
    `CHECK(rdq.size(), num)
    while (rdq.size() > 0 && expq.size() > 0) begin
      g = rdq.pop_front();
      e = expq.pop_front();
      `CHECK(g, 8'(e))
    end
    expq.delete();
  endtask
  task automatic prog(input logic [7:0] f, input logic [7:0] cc, input int lim, input logic sl);
    d = 8'($urandom);
    do_req(nand_host_pkg::OP_CMD, f);
    `CHECK(timeoutErr, 1'b0)
    do_req(nand_host_pkg::OP_ADDR, 8'h00);
    do_req(nand_host_pkg::OP_WRITE, d);
    `CHECK(nand_dev_model_inst.wrData, d)
    busy_cmd(cc, lim, sl);
  endtask
  initial begin
    rstn = 0;
    reqValid = 0;
    req = '0;
    protect = 0;
    busyLen = 16'h0001;
    r = 17'h00000;
    c = 13'h0000;
    void'($urandom(32'hEBC1));
    repeat (20) @(posedge ref_clk);
    `CHECK(pins.chipSel_n, 1'b1)
    `CHECK(pins.writeProt_n, 1'b0)
    `CHECK(ioOe_n, 1'b1)
    #1 rstn = 1;
    for (int k = 0; k < 2; k++) begin
      r = 17'($urandom);
      c = 13'($urandom_range(4351, 0));
      do_req(nand_host_pkg::OP_CMD, 8'h00);
      do_req(nand_host_pkg::OP_ADDR, 8'h00);
      `CHECK(nand_dev_model_inst.addrR, {7'h00, r, 3'h0, c})
      busy_cmd(8'h30, LOAD, k[0]);
      read_n(3);
      busy_cmd(8'h31, CR, k[0]);
      read_n(2);
      busy_cmd(8'h3F, CR, k[0]);
      read_n(2);
      busy_cmd(8'h3A, COPY, k[0]);
      prog(8'h80, 8'h11, SHORT, k[0]);
      prog(8'h81, 8'h15, CWLONG, k[0]);
      do_req(nand_host_pkg::OP_CMD, 8'h70);
      do_req(nand_host_pkg::OP_CMD, 8'hFF);
      do_req(nand_host_pkg::OP_WAIT, 8'h00);
      `CHECK(rbLevel, 1'b1)
      prog(8'h81, 8'h10, 60, 1'b0);
    end
    protect = 1;
    n = nand_dev_model_inst.progStarts;
    prog(8'h80, 8'h10, 60, 1'b0);
    `CHECK(nand_dev_model_inst.progStarts, n)
    `CHECK(pins.writeProt_n, 1'b0)
    tally_and_finish();
  end
endmodule
